// *** rtl/cad_pkg.sv ***
// cad_pkg: constants and carrier types for the cpu arithmetic datapath.
// assumes one 40 MHz instruction clock and an apb master for the core registers.
package cad_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00; // cpu_status_flags
    localparam logic [7:0] ADDR_CORE = 8'h04; // core_control
    localparam logic [7:0] ADDR_AUX = 8'h08; // nesting disable and visibility page
    // cpu_status_flags fields
    localparam int DC_BIT = 8;
    localparam int IPL_LSB = 5;
    localparam int RA_BIT = 4;
    localparam int N_BIT = 3;
    localparam int OV_BIT = 2;
    localparam int Z_BIT = 1;
    localparam int C_BIT = 0;
    // core_control fields
    localparam int CPU_PRIORITY_HIGH_BIT_BIT = 3;
    localparam int PSV_BIT = 2;
    // aux register fields
    localparam int NESTING_DISABLE_BIT = 15;
    localparam int PAGE_LSB = 0;
    // reset values
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] CORE_RST = 16'h0000;
    localparam logic [15:0] AUX_RST = 16'h0000;
    localparam logic [2:0] IPL_TOP = 3'h7; // highest low priority level
    // divide timing in instruction cycles
    localparam logic [4:0] DIV_CYCLES = 5'h13; // 19 cycles accept to result
    localparam logic [4:0] DIV_LAST_ITER = 5'h10; // 16 quotient bits
    localparam logic [4:0] DIV_FIX = 5'h11; // sign correction step
    localparam logic [4:0] DIV_END = 5'h12; // result write step

    typedef enum logic [2:0] {CAD_ADD, CAD_SUB, CAD_AND, CAD_IOR, CAD_XOR, CAD_SHIFT, CAD_MUL, CAD_DIV} cad_op_t;
    typedef enum logic [2:0] {MUL_SS, MUL_UU, MUL_SLIT, MUL_ULIT, MUL_US, MUL_B8} cad_mul_t;
    typedef enum logic [1:0] {DIV_S32, DIV_U32, DIV_S16, DIV_U16} cad_div_t;

    // one instruction from the decoder
    typedef struct packed {
        cad_op_t op;
        logic byte_mode; // 8-bit alu operation
        cad_mul_t mul_mode;
        cad_div_t div_mode;
        logic shift_arith; // right shifts fill with sign
        logic [15:0] a; // source, or dividend low word
        logic [15:0] b; // source, literal, shift amount or divisor
        logic [15:0] a_hi; // dividend high word
    } cad_req_t;

    // one result for the write-back stage
    typedef struct packed {
        logic valid;
        logic div_pair; // write quotient and remainder to working regs 0 and 1
        logic [31:0] data; // result, product, or quotient in the low word
        logic [15:0] rem; // remainder
    } cad_res_t;
endpackage

// *** rtl/cad_core.sv ***
// cad_core: alu, flags, multiplier, iterative divider, shifter and core registers.
// assumes the decoder holds div_hold_i while an interrupt borrows the pipeline.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module cad_core (
    input wire logic clk_sys_i, // 40 MHz instruction clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [7:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error on unmapped address
    input wire logic op_valid_i, // decoder issues req_i
    input wire cad_pkg::cad_req_t req_i, // instruction operands and mode
    input wire logic div_hold_i, // freeze divide while interrupted
    input wire logic repeat_active_i, // repeat loop running in the sequencer
    input wire logic ipl_high_set_i, // interrupt entry above level 7
    input wire logic [15:0] ea_i, // data effective address
    output cad_pkg::cad_res_t res_o, // registered result
    output logic div_busy_o, // divide in progress
    output logic [3:0] cpu_priority_o, // combined priority
    output logic user_irq_disable_o, // user interrupts blocked
    output logic psv_hit_o, // ea falls in visible program window
    output logic [22:0] psv_addr_o // program address for that window
);
    // status and control state
    logic [15:0] status_reg, status_next; // cpu_status_flags
    logic cpu_priority_high_bit_reg, cpu_priority_high_bit_next; // cpu_priority_high_bit
    logic psv_reg, psv_next; // program_visibility_enable
    logic nesting_disable_reg, nesting_disable_next; // nesting_disable
    logic [7:0] page_reg, page_next; // program_visibility_page
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, perr_reg, perr_next;
    logic [3:0] prio_reg, prio_next;
    logic udis_reg, udis_next, hit_reg, hit_next;
    logic [22:0] pa_reg, pa_next;
    // datapath result
    cad_pkg::cad_res_t res_reg, res_next;
    logic [15:0] aflags; // flag update mask from the alu
    logic [15:0] avals; // flag values from the alu
    // divider state
    logic busy_reg, busy_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [15:0] rem_reg, rem_next, q_reg, q_next, dv_reg, dv_next;
    logic negq_reg, negq_next, negr_reg, negr_next;

    // two's complement negate, used on divisor and results
    function automatic logic [15:0] neg16(input logic [15:0] v);
        return 16'h0000 - v;
    endfunction

    // a write cycle in the apb access phase
    wire wr_acc = psel_i & penable_i & pwrite_i;
    wire start_div = op_valid_i & (req_i.op == cad_pkg::CAD_DIV) & ~busy_reg;

    // alu, shifter and multiplier: combinational results and flag updates
    always_comb begin
        logic [16:0] w;
        logic [8:0] lo;
        logic [4:0] nib;
        logic [15:0] bb, r;
        logic [5:0] amt;
        logic sub, msb, amsb, bmsb, c, dc;
        logic [16:0] ma, mb;
        logic [33:0] p;
        w = '0;
        lo = '0;
        nib = '0;
        bb = '0;
        r = '0;
        amt = '0;
        sub = 1'b0;
        msb = 1'b0;
        amsb = 1'b0;
        bmsb = 1'b0;
        c = 1'b0;
        dc = 1'b0;
        ma = '0;
        mb = '0;
        p = '0;
        res_next = '0;
        aflags = '0;
        avals = '0;
        if (op_valid_i) begin
            case (req_i.op)
                cad_pkg::CAD_ADD, cad_pkg::CAD_SUB: begin
                    sub = (req_i.op == cad_pkg::CAD_SUB);
                    // subtract adds the inverse plus one, so carry set means no borrow
                    bb = sub ? ~req_i.b : req_i.b;
                    w = {1'b0, req_i.a} + {1'b0, bb} + {16'h0000, sub};
                    lo = {1'b0, req_i.a[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub};
                    nib = {1'b0, req_i.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
                    r = req_i.byte_mode ? {8'h00, lo[7:0]} : w[15:0];
                    c = req_i.byte_mode ? lo[8] : w[16];
                    dc = req_i.byte_mode ? nib[4] : lo[8];
                    amsb = req_i.byte_mode ? req_i.a[7] : req_i.a[15];
                    bmsb = req_i.byte_mode ? bb[7] : bb[15];
                    msb = req_i.byte_mode ? r[7] : r[15];
                    aflags[cad_pkg::C_BIT] = 1'b1;
                    aflags[cad_pkg::DC_BIT] = 1'b1;
                    aflags[cad_pkg::OV_BIT] = 1'b1;
                    avals[cad_pkg::C_BIT] = c;
                    avals[cad_pkg::DC_BIT] = dc;
                    avals[cad_pkg::OV_BIT] = (amsb == bmsb) & (msb != amsb);
                end
                cad_pkg::CAD_AND: r = req_i.a & req_i.b;
                cad_pkg::CAD_IOR: r = req_i.a | req_i.b;
                cad_pkg::CAD_XOR: r = req_i.a ^ req_i.b;
                cad_pkg::CAD_SHIFT: begin
                    // amount is signed: magnitude 16 empties the word or fills with sign
                    amt = req_i.b[5:0];
                    if (amt[5]) begin
                        r = req_i.a << (6'h00 - amt);
                    end else if (req_i.shift_arith) begin
                        r = 16'($signed(req_i.a) >>> amt);
                    end else begin
                        r = req_i.a >> amt;
                    end
                end
                cad_pkg::CAD_MUL: begin
                    // every mode is one signed 17x17 product with mode-chosen extension
                    case (req_i.mul_mode)
                        cad_pkg::MUL_SS: begin
                            ma = {req_i.a[15], req_i.a};
                            mb = {req_i.b[15], req_i.b};
                        end
                        cad_pkg::MUL_SLIT: begin
                            ma = {req_i.a[15], req_i.a};
                            mb = {12'h000, req_i.b[4:0]};
                        end
                        cad_pkg::MUL_ULIT: begin
                            ma = {1'b0, req_i.a};
                            mb = {12'h000, req_i.b[4:0]};
                        end
                        cad_pkg::MUL_US: begin
                            ma = {1'b0, req_i.a};
                            mb = {req_i.b[15], req_i.b};
                        end
                        cad_pkg::MUL_B8: begin
                            ma = {9'h000, req_i.a[7:0]};
                            mb = {9'h000, req_i.b[7:0]};
                        end
                        default: begin
                            ma = {1'b0, req_i.a};
                            mb = {1'b0, req_i.b};
                        end
                    endcase
                    p = 34'($signed(ma) * $signed(mb));
                    res_next.data = p[31:0];
                end
                default: ;
            endcase
            // logic, shift and arithmetic all report sign and zero
            if (req_i.op != cad_pkg::CAD_MUL && req_i.op != cad_pkg::CAD_DIV) begin
                if (req_i.byte_mode && req_i.op != cad_pkg::CAD_SHIFT) begin
                    r = {8'h00, r[7:0]};
                end
                msb = (req_i.byte_mode && req_i.op != cad_pkg::CAD_SHIFT) ? r[7] : r[15];
                res_next.data = {16'h0000, r};
                res_next.valid = 1'b1;
                aflags[cad_pkg::N_BIT] = 1'b1;
                aflags[cad_pkg::Z_BIT] = 1'b1;
                avals[cad_pkg::N_BIT] = msb;
                avals[cad_pkg::Z_BIT] = (r == 16'h0000);
            end
            res_next.valid = (req_i.op != cad_pkg::CAD_DIV);
        end
        // a finishing divide takes the result slot
        if (busy_reg && !div_hold_i && cnt_reg == cad_pkg::DIV_END) begin
            res_next = '0;
            res_next.valid = 1'b1;
            res_next.div_pair = 1'b1;
            res_next.data = {16'h0000, q_reg};
            res_next.rem = rem_reg;
        end
    end

    // divider: restoring, one quotient bit per step, frozen while held
    always_comb begin
        logic [16:0] t;
        logic [31:0] dd;
        logic sgn, wide;
        t = '0;
        dd = '0;
        sgn = 1'b0;
        wide = 1'b0;
        busy_next = busy_reg;
        cnt_next = cnt_reg;
        rem_next = rem_reg;
        q_next = q_reg;
        dv_next = dv_reg;
        negq_next = negq_reg;
        negr_next = negr_reg;
        if (start_div) begin
            sgn = (req_i.div_mode == cad_pkg::DIV_S32) | (req_i.div_mode == cad_pkg::DIV_S16);
            wide = (req_i.div_mode == cad_pkg::DIV_S32) | (req_i.div_mode == cad_pkg::DIV_U32);
            dd = wide ? {req_i.a_hi, req_i.a} : {{16{sgn & req_i.a[15]}}, req_i.a};
            negr_next = sgn & dd[31];
            negq_next = sgn & (dd[31] ^ req_i.b[15]);
            if (sgn & dd[31]) begin
                dd = 32'h0000_0000 - dd;
            end
            rem_next = dd[31:16];
            q_next = dd[15:0];
            dv_next = (sgn & req_i.b[15]) ? neg16(req_i.b) : req_i.b;
            busy_next = 1'b1;
            cnt_next = 5'h01;
        end else if (busy_reg && !div_hold_i) begin
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg <= cad_pkg::DIV_LAST_ITER) begin
                // same count for 16 and 32 bit dividends
                t = {rem_reg, q_reg[15]};
                if (t >= {1'b0, dv_reg}) begin
                    rem_next = 16'(t - {1'b0, dv_reg});
                    q_next = {q_reg[14:0], 1'b1};
                end else begin
                    rem_next = t[15:0];
                    q_next = {q_reg[14:0], 1'b0};
                end
            end else if (cnt_reg == cad_pkg::DIV_FIX) begin
                // quotient truncates toward zero, remainder takes dividend sign
                q_next = negq_reg ? neg16(q_reg) : q_reg;
                rem_next = negr_reg ? neg16(rem_reg) : rem_reg;
            end else begin
                busy_next = 1'b0;
                cnt_next = 5'h00;
            end
        end
    end

    // core registers, apb answer and priority outputs
    always_comb begin
        logic hit;
        hit = 1'b1;
        status_next = (status_reg & ~aflags) | (avals & aflags);
        cpu_priority_high_bit_next = cpu_priority_high_bit_reg;
        psv_next = psv_reg;
        nesting_disable_next = nesting_disable_reg;
        page_next = page_reg;
        prdata_next = prdata_reg;
        case (paddr_i)
            cad_pkg::ADDR_STATUS, cad_pkg::ADDR_CORE, cad_pkg::ADDR_AUX: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        // setup phase: answer is ready for the first access cycle
        pready_next = psel_i & ~penable_i;
        perr_next = psel_i & ~penable_i & ~hit;
        if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                cad_pkg::ADDR_STATUS: prdata_next = {16'h0000, status_reg};
                cad_pkg::ADDR_CORE: prdata_next = {28'h0000000, cpu_priority_high_bit_reg, psv_reg, 2'b00};
                cad_pkg::ADDR_AUX: prdata_next = {16'h0000, nesting_disable_reg, 7'h00, page_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_acc && pready_reg) begin
            case (paddr_i)
                cad_pkg::ADDR_STATUS: begin
                    // software write, then any same-cycle alu update on top
                    status_next[cad_pkg::DC_BIT] = pwdata_i[cad_pkg::DC_BIT];
                    status_next[3:0] = pwdata_i[3:0];
                    if (!nesting_disable_reg) begin
                        status_next[7:5] = pwdata_i[7:5];
                    end
                    status_next = (status_next & ~aflags) | (avals & aflags);
                end
                cad_pkg::ADDR_CORE: begin
                    cpu_priority_high_bit_next = cpu_priority_high_bit_reg & pwdata_i[cad_pkg::CPU_PRIORITY_HIGH_BIT_BIT];
                    psv_next = pwdata_i[cad_pkg::PSV_BIT];
                end
                cad_pkg::ADDR_AUX: begin
                    nesting_disable_next = pwdata_i[cad_pkg::NESTING_DISABLE_BIT];
                    page_next = pwdata_i[7:0];
                end
                default: ;
            endcase
        end
        if (ipl_high_set_i) begin
            cpu_priority_high_bit_next = 1'b1;
        end
        status_next[15:9] = 7'h00;
        status_next[cad_pkg::RA_BIT] = repeat_active_i | busy_next;
        prio_next = {cpu_priority_high_bit_next, status_next[7:5]};
        udis_next = cpu_priority_high_bit_next | (status_next[7:5] == cad_pkg::IPL_TOP);
        // upper half of data space reads program memory at the chosen page
        hit_next = psv_reg & ea_i[15];
        pa_next = {page_reg, ea_i[14:0]};
    end

    // registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= cad_pkg::STATUS_RST;
            cpu_priority_high_bit_reg <= cad_pkg::CORE_RST[cad_pkg::CPU_PRIORITY_HIGH_BIT_BIT];
            psv_reg <= cad_pkg::CORE_RST[cad_pkg::PSV_BIT];
            nesting_disable_reg <= cad_pkg::AUX_RST[cad_pkg::NESTING_DISABLE_BIT];
            page_reg <= cad_pkg::AUX_RST[7:0];
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            perr_reg <= 1'b0;
            prio_reg <= '0;
            udis_reg <= 1'b0;
            hit_reg <= 1'b0;
            pa_reg <= '0;
            res_reg <= '0;
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            rem_reg <= '0;
            q_reg <= '0;
            dv_reg <= '0;
            negq_reg <= 1'b0;
            negr_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            cpu_priority_high_bit_reg <= cpu_priority_high_bit_next;
            psv_reg <= psv_next;
            nesting_disable_reg <= nesting_disable_next;
            page_reg <= page_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            perr_reg <= perr_next;
            prio_reg <= prio_next;
            udis_reg <= udis_next;
            hit_reg <= hit_next;
            pa_reg <= pa_next;
            res_reg <= res_next;
            busy_reg <= busy_next;
            cnt_reg <= cnt_next;
            rem_reg <= rem_next;
            q_reg <= q_next;
            dv_reg <= dv_next;
            negq_reg <= negq_next;
            negr_reg <= negr_next;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = perr_reg;
    assign res_o = res_reg;
    assign div_busy_o = busy_reg;
    assign cpu_priority_o = prio_reg;
    assign user_irq_disable_o = udis_reg;
    assign psv_hit_o = hit_reg;
    assign psv_addr_o = pa_reg;

    // checking helpers: unheld divide cycles since accept
    logic [4:0] h_run;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            h_run <= '0;
        end else if (start_div) begin
            h_run <= 5'h01;
        end else if (busy_reg && !div_hold_i) begin
            h_run <= h_run + 5'h01;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_mul_ss;
        op_valid_i && req_i.op == cad_pkg::CAD_MUL && req_i.mul_mode == cad_pkg::MUL_SS
            |=> $signed(res_o.data) == $signed($past(req_i.a)) * $signed($past(req_i.b));
    endproperty
    a_mul_ss: assert property (p_mul_ss) else $error("signed product wrong");
    property p_mul_b8;
        op_valid_i && req_i.op == cad_pkg::CAD_MUL && req_i.mul_mode == cad_pkg::MUL_B8
            |=> res_o.valid && res_o.data == 32'($past(req_i.a[7:0])) * 32'($past(req_i.b[7:0]));
    endproperty
    a_mul_b8: assert property (p_mul_b8) else $error("byte product wrong");
    property p_div_len;
        res_o.valid && res_o.div_pair |-> h_run == cad_pkg::DIV_CYCLES;
    endproperty
    a_div_len: assert property (p_div_len) else $error("divide length wrong");
    property p_div_hold;
        busy_reg && div_hold_i && !start_div |=> $stable(cnt_reg) && $stable(q_reg) && $stable(rem_reg);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("held divide moved");
    property p_shift_zero;
        op_valid_i && req_i.op == cad_pkg::CAD_SHIFT && req_i.b[5:0] == 6'h00
            |=> res_o.data[15:0] == $past(req_i.a);
    endproperty
    a_shift_zero: assert property (p_shift_zero) else $error("zero shift changed data");
    property p_shift_left;
        op_valid_i && req_i.op == cad_pkg::CAD_SHIFT && req_i.b[5]
            |=> res_o.data[15:0] == 16'($past(req_i.a) << (6'h00 - $past(req_i.b[5:0])));
    endproperty
    a_shift_left: assert property (p_shift_left) else $error("left shift wrong");
    property p_carry;
        op_valid_i && req_i.op == cad_pkg::CAD_ADD && !req_i.byte_mode
            |=> status_reg[cad_pkg::C_BIT] == $past(17'({1'b0, req_i.a} + {1'b0, req_i.b}) >> 16);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    property p_ipl_lock;
        nesting_disable_reg && wr_acc && paddr_i == cad_pkg::ADDR_STATUS |=> $stable(status_reg[7:5]);
    endproperty
    a_ipl_lock: assert property (p_ipl_lock) else $error("locked priority written");
    property p_cpu_priority_high_bit_clear_only;
        !cpu_priority_high_bit_reg && !ipl_high_set_i |=> !cpu_priority_high_bit_reg;
    endproperty
    a_cpu_priority_high_bit_clear_only: assert property (p_cpu_priority_high_bit_clear_only) else $error("high bit set by write");
    property p_udis;
        ##1 user_irq_disable_o == (cpu_priority_o[3] | (cpu_priority_o[2:0] == cad_pkg::IPL_TOP));
    endproperty
    a_udis: assert property (p_udis) else $error("user disable mismatch");
    property p_ra;
        status_reg[cad_pkg::RA_BIT] == (busy_reg | $past(repeat_active_i));
    endproperty
    a_ra: assert property (p_ra) else $error("loop flag wrong");

    c_div: cover property (start_div ##1 busy_reg [*3] ##1 div_hold_i);
    c_sub_borrow: cover property (op_valid_i && req_i.op == cad_pkg::CAD_SUB ##1 !status_reg[cad_pkg::C_BIT]);
    c_psv: cover property (psv_hit_o);
endmodule // cad_core

// *** sim/cad_wregs.sv ***
// cad_wregs: write-back model holding working regs zero and one.
// assumes res_i comes straight from the datapath result port.
`timescale 1ns/1ps
module cad_wregs (
    input wire logic clk_sys_i, // instruction clock
    input wire logic rst_n_i, // async reset, active low
    input wire cad_pkg::cad_res_t res_i, // datapath result
    output logic [15:0] w0_o, // working reg zero
    output logic [15:0] w1_o // working reg one
);
    // a divide pair lands in both regs at once, other results go elsewhere
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w0_o <= 16'h0000;
            w1_o <= 16'h0000;
        end else if (res_i.valid && res_i.div_pair) begin
            w0_o <= res_i.data[15:0];
            w1_o <= res_i.rem;
        end
    end
endmodule // cad_wregs

// *** sim/tb_top.sv ***
// tb_top: apb and instruction bench for cad_core.
// assumes cad_wregs stands in for the write-back side.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
    logic op_valid_i = 0, div_hold_i = 0, repeat_active_i = 0, ipl_high_set_i = 0;
    logic div_busy_o, user_irq_disable_o, psv_hit_o;
    logic [7:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o;
    logic [15:0] ea_i = 0, w0, w1;
    logic [3:0] cpu_priority_o;
    logic [22:0] psv_addr_o;
    cad_pkg::cad_req_t req_i = '0;
    cad_pkg::cad_res_t res_o;
    int err_total = 0, n_tests = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    cad_core dut (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .op_valid_i, .req_i, .div_hold_i, .repeat_active_i, .ipl_high_set_i,
        .ea_i, .res_o, .div_busy_o, .cpu_priority_o, .user_irq_disable_o, .psv_hit_o, .psv_addr_o);
    cad_wregs wr (.clk_sys_i, .rst_n_i, .res_i(res_o), .w0_o(w0), .w1_o(w1));
    task finish_test;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // a stuck handshake ends the run instead of hanging it
    task lim(input int n);
        if (n >= 40) begin
            err_total++;
            finish_test;
        end
    endtask
    // apb transfer; the request is held until pready is seen
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, ex);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= wd;
        @(posedge clk_sys_i);
        penable_i <= 1;
        n = 0;
        // ready, read data and error are all taken at the rising edge that sees ready high
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 40);
        lim(n);
        if (!w) chk(prdata_o, ex);
        chk(pslverr_o, ad > 8'h08);
        psel_i <= 0;
        penable_i <= 0;
    endtask
    // one instruction; md carries the mode, lat the cycles to a result
    task op(input logic [2:0] o, md, input logic [15:0] ah, a, b, input logic [31:0] ex, input int lat);
        int n;
        @(posedge clk_sys_i);
        op_valid_i <= 1;
        req_i <= '{op: cad_pkg::cad_op_t'(o), byte_mode: md[0], mul_mode: cad_pkg::cad_mul_t'(md),
            div_mode: cad_pkg::cad_div_t'(md[1:0]), shift_arith: md[0], a: a, b: b, a_hi: ah};
        @(posedge clk_sys_i);
        op_valid_i <= 0;
        #1;
        if (o == 3'h7) chk(div_busy_o, 1);
        n = 0;
        while (res_o.valid !== 1'b1 && n < 40) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        lim(n);
        chk(n, lat);
        if (o == 3'h7) begin
            @(posedge clk_sys_i);
            #1;
            chk({w1, w0}, ex);
            chk(div_busy_o, 0);
        end
        else chk(res_o.data, ex);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1;
        apb(0, 8'h00, 0, 0);
        apb(0, 8'h0c, 0, 0);
        op(0, 0, 0, 16'h7fff, 1, 32'h8000, 0);
        apb(0, 8'h00, 0, 32'h010c);
        op(0, 1, 0, 16'h00ff, 1, 0, 0);
        apb(0, 8'h00, 0, 32'h0103);
        op(1, 0, 0, 5, 5, 0, 0);
        apb(0, 8'h00, 0, 32'h0103);
        op(1, 0, 0, 3, 5, 32'hfffe, 0);
        apb(0, 8'h00, 0, 32'h0008);
        op(4, 0, 0, 16'hf0f0, 16'h3c3c, 32'hcccc, 0);
        op(6, 0, 0, 16'hffff, 2, 32'hfffffffe, 0);
        op(6, 1, 0, 16'hffff, 2, 32'h0001fffe, 0);
        op(6, 2, 0, 16'hffff, 16'h001f, 32'hffffffe1, 0);
        op(6, 3, 0, 16'hffff, 16'h001f, 32'h001effe1, 0);
        op(6, 4, 0, 2, 16'hffff, 32'hfffffffe, 0);
        op(6, 5, 0, 16'h00ff, 16'h00ff, 32'h0000fe01, 0);
        op(5, 0, 0, 16'h8000, 2, 32'h2000, 0);
        op(5, 1, 0, 16'h8000, 16'h0010, 32'hffff, 0);
        op(5, 0, 0, 1, 16'h003e, 32'h0004, 0);
        op(5, 0, 0, 16'h1234, 0, 32'h1234, 0);
        op(7, 3, 0, 100, 7, 32'h0002000e, 18);
        op(7, 2, 0, 16'hff9c, 7, 32'hfffefff2, 18);
        op(7, 1, 16'h0001, 16'h86a3, 16'd1000, 32'h00030064, 18);
        // three held cycles in mid-divide stretch it without changing it
        fork
            begin
                repeat (5) @(posedge clk_sys_i);
                div_hold_i <= 1;
                repeat (3) @(posedge clk_sys_i);
                div_hold_i <= 0;
            end
        join_none
        op(7, 0, 16'hfffe, 16'h795d, 16'd1000, 32'hfffdff9c, 21);
        apb(1, 8'h00, 32'h00e0, 0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(cpu_priority_o, 4'h7);
        chk(user_irq_disable_o, 1);
        @(posedge clk_sys_i);
        ipl_high_set_i <= 1;
        @(posedge clk_sys_i);
        ipl_high_set_i <= 0;
        apb(0, 8'h04, 0, 32'h0008);
        apb(1, 8'h04, 32'h0004, 0);
        apb(1, 8'h04, 32'h000c, 0);
        apb(0, 8'h04, 0, 32'h0004);
        apb(1, 8'h08, 32'h8012, 0);
        apb(1, 8'h00, 32'h0000, 0);
        ea_i <= 16'h8123;
        repeat_active_i <= 1;
        apb(0, 8'h00, 0, 32'h00f0);
        #1;
        chk(psv_hit_o, 1);
        chk(psv_addr_o, 23'h090123);
        finish_test;
    end
endmodule // tb_top
